// ==== logic/smi_pkg.sv ====
// package of constants for the sdram and async memory interface
package smi_pkg;
  // sdram command encodings {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;
  // initialization wait in ns and cycles at 50 ns
  localparam int INIT_WAIT_NS = 200000;
  localparam int CLK_NS = 50;
  localparam int INIT_WAIT_CYC = INIT_WAIT_NS / CLK_NS;
  // fixed sdram gaps in cycles (trp, trcd, trfc, cas latency)
  localparam logic [3:0] SD_GAP = 4'h3;
  localparam logic [3:0] SD_RFC = 4'h8;
  // number of auto refreshes during init
  localparam logic [3:0] INIT_REFS = 4'h8;
  // mode register value: burst length 1, cas latency 3
  localparam logic [12:0] MODE_VAL = 13'h0030;
  // parked data bus value
  localparam logic [31:0] PARK_VAL = 32'h0000_0000;
  // reset value of the refresh interval
  localparam logic [12:0] REFR_RST = 13'h04E2;
  // main sequencer states
  typedef enum logic [3:0] {
    ST_INIT = 4'b0000, ST_IWAIT = 4'b0001, ST_IPRE = 4'b0010, ST_IREF = 4'b0011,
    ST_IMRS = 4'b0100, ST_IDLE = 4'b0101, ST_ACT = 4'b0110, ST_RW = 4'b0111,
    ST_PRE = 4'b1000, ST_REF = 4'b1001, ST_GAP = 4'b1010, ST_SELF = 4'b1011,
    ST_ASU = 4'b1100, ST_AST = 4'b1101, ST_AHO = 4'b1110
  } smi_state_e;
endpackage

// ==== logic/smi_top.sv ====
// sdram plus async memory interface controller
//
// How it works
// - single clock from pll derived system domain
// - sdram width sixteen or thirty-two only
// - wait input polarity chosen by software
// - wait extension capped by programmable maximum
// - timeout raises interrupt when enabled
// - no bus hold handshake provided
// - sdram row/column on addr, bank separate
// - async word address on address bus
// - bank lines carry word address bits 13 and 14, zero at x32
// - select zero sdram, select two async
// - only sdr sdram as synchronous memory
// - select strobe: select in strobe only
// - we strobe: select whole, lanes strobe
// - init at reset exit or config write
// - incrementing addresses walk columns first, then banks, then rows
// - async hold lasts at least one cycle
// - timing fields are count minus one
// - data bus driven while idle
// - self-refresh entry for clock changes
// - read/write level high read, low write
// - raw, masked, mask set/clear interrupt controls
`timescale 1ns/1ps
`default_nettype none
module smi_top (
  // clock and reset
  input wire logic clk, // pll_derived_clock
  input wire logic nrst,
  // processor-side request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_async, // 1 selects async space
  input wire logic req_write,
  input wire logic [23:0] req_addr, // word address
  input wire logic [3:0] req_be,
  input wire logic [31:0] req_wdata,
  output logic [31:0] rsp_rdata,
  output logic rsp_valid,
  // sdram configuration
  input wire logic [2:0] sdcfg_wr_bytes, // byte writes to low three config bytes
  input wire logic sdcfg_narrow, // 1 = x16, else x32
  input wire logic [12:0] refr_interval,
  input wire logic self_refresh_req,
  output logic self_refresh_ack,
  // async configuration
  input wire logic acfg_we_strobe, // 1 = we strobe mode
  input wire logic [1:0] acfg_width, // 0 x8, 1 x16, 2 x32
  input wire logic [3:0] acfg_setup,
  input wire logic [5:0] acfg_strobe,
  input wire logic [2:0] acfg_hold,
  input wire logic wait_pol, // 1 = wait active high
  input wire logic [7:0] wait_max,
  // interrupt controls
  input wire logic irq_clear,
  input wire logic irq_mask_set,
  input wire logic irq_mask_clr,
  output logic irq_raw,
  output logic irq_masked,
  output logic irq_mask,
  output logic irq,
  // memory pins
  output logic [12:0] mem_addr_bus,
  output logic [1:0] bank_addr_lines,
  output logic sdram_chip_sel_n,
  output logic async_chip_sel_n,
  output logic [3:0] byte_strobe_lines_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic oe_n,
  output logic read_write_level,
  output logic [31:0] dq_out,
  output logic dq_oe_n, // low while driving
  input wire logic [31:0] dq_in,
  input wire logic ext_wait_in
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  smi_pkg::smi_state_e st_q; // sequencer state
  logic [15:0] cnt_q; // generic delay/period counter
  logic [3:0] nref_q; // init refresh counter
  logic [12:0] rtmr_q; // refresh interval timer
  logic ref_due_q; // refresh owed
  logic init_pend_q; // config write waiting for idle
  logic [7:0] wcnt_q; // wait extension counter
  logic req_w_q; // latched direction
  logic [23:0] addr_q; // latched word address
  logic [3:0] be_q;
  logic [31:0] wdat_q;
  logic [1:0] bank_q;
  logic [12:0] row_q;
  logic [8:0] col_q;
  // wait level in active sense
  logic wait_act;
  assign wait_act = ext_wait_in == wait_pol;
  // hold used as programmed; a zero still gives one hold cycle, since fields are count minus one
  logic [2:0] hold_eff;
  assign hold_eff = acfg_hold;

  // bank interleave: bank sits just above the column bits, so a linear
  // walk visits every bank before the row changes
  // split from the latched address, which stands for the whole access
  always_comb begin
    if (sdcfg_narrow) begin
      // x16: two sdram columns per word
      col_q = {addr_q[7:0], 1'b0};
      bank_q = addr_q[9:8];
      row_q = addr_q[22:10];
    end else begin
      col_q = {1'b0, addr_q[7:0]};
      bank_q = addr_q[9:8];
      row_q = addr_q[22:10];
    end
  end

  // sole master of the pins: there is no hold request or grant to honour
  assign req_ready = (st_q == smi_pkg::ST_IDLE) && !ref_due_q && !init_pend_q
    && !self_refresh_req;
  logic take;
  assign take = req_valid && req_ready;
  logic cfg_wr;
  assign cfg_wr = |sdcfg_wr_bytes;

  // -----------------------------------------------------------------
  // refresh timer
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rtmr_q <= smi_pkg::REFR_RST;
      ref_due_q <= 1'b0;
    end else if (st_q == smi_pkg::ST_SELF || st_q == smi_pkg::ST_REF) begin
      rtmr_q <= refr_interval;
      ref_due_q <= 1'b0;
    end else if (rtmr_q == 13'h0000) begin
      rtmr_q <= refr_interval;
      ref_due_q <= 1'b1;
    end else begin
      rtmr_q <= rtmr_q - 13'h0001;
    end
  end

  // pending init from config write, held until current access ends
  always_ff @(posedge clk) begin
    if (!nrst) begin
      init_pend_q <= 1'b0;
    end else if (cfg_wr) begin
      init_pend_q <= 1'b1;
    end else if (st_q == smi_pkg::ST_INIT) begin
      init_pend_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= smi_pkg::ST_INIT;
      cnt_q <= 16'h0000;
      nref_q <= 4'h0;
      wcnt_q <= 8'h00;
      req_w_q <= 1'b0;
      addr_q <= 24'h00_0000;
      be_q <= 4'h0;
      wdat_q <= 32'h0000_0000;
    end else begin
      case (st_q)
        smi_pkg::ST_INIT: begin
          cnt_q <= 16'(smi_pkg::INIT_WAIT_CYC);
          st_q <= smi_pkg::ST_IWAIT;
        end
        smi_pkg::ST_IWAIT: begin
          // power-up wait; software handles a violated constraint
          if (cnt_q == 16'h0000) begin
            st_q <= smi_pkg::ST_IPRE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        smi_pkg::ST_IPRE: begin
          cnt_q <= {12'h000, smi_pkg::SD_GAP};
          nref_q <= smi_pkg::INIT_REFS;
          st_q <= smi_pkg::ST_IREF;
        end
        smi_pkg::ST_IREF: begin
          // one refresh each time the gap expires while refreshes remain; the last expiry goes to mode set
          if (cnt_q == 16'h0000) begin
            if (nref_q == 4'h0) begin
              st_q <= smi_pkg::ST_IMRS;
            end else begin
              nref_q <= nref_q - 4'h1;
              cnt_q <= {12'h000, smi_pkg::SD_RFC};
            end
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        smi_pkg::ST_IMRS: begin
          cnt_q <= {12'h000, smi_pkg::SD_GAP};
          st_q <= smi_pkg::ST_GAP;
        end
        smi_pkg::ST_IDLE: begin
          // priority: init, self refresh, refresh, then access
          if (init_pend_q) begin
            st_q <= smi_pkg::ST_INIT;
          end else if (self_refresh_req) begin
            st_q <= smi_pkg::ST_PRE;
          end else if (ref_due_q) begin
            st_q <= smi_pkg::ST_PRE;
          end else if (take) begin
            req_w_q <= req_write;
            addr_q <= req_addr;
            be_q <= req_be;
            wdat_q <= req_wdata;
            wcnt_q <= 8'h00;
            if (req_async) begin
              cnt_q <= {12'h000, acfg_setup};
              st_q <= smi_pkg::ST_ASU;
            end else begin
              cnt_q <= {12'h000, smi_pkg::SD_GAP};
              st_q <= smi_pkg::ST_ACT;
            end
          end
        end
        smi_pkg::ST_ACT: begin
          if (cnt_q == 16'h0000) begin
            cnt_q <= {12'h000, smi_pkg::SD_GAP};
            st_q <= smi_pkg::ST_RW;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        smi_pkg::ST_RW: begin
          // wait out cas latency, then close the row
          if (cnt_q == 16'h0000) begin
            cnt_q <= {12'h000, smi_pkg::SD_GAP};
            st_q <= smi_pkg::ST_GAP;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        smi_pkg::ST_PRE: begin
          cnt_q <= {12'h000, smi_pkg::SD_GAP};
          st_q <= self_refresh_req ? smi_pkg::ST_SELF : smi_pkg::ST_REF;
        end
        smi_pkg::ST_REF: begin
          cnt_q <= {12'h000, smi_pkg::SD_RFC};
          st_q <= smi_pkg::ST_GAP;
        end
        smi_pkg::ST_GAP: begin
          if (cnt_q == 16'h0000) begin
            st_q <= smi_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        smi_pkg::ST_SELF: begin
          // memory refreshes itself until software releases it
          if (!self_refresh_req) begin
            cnt_q <= {12'h000, smi_pkg::SD_RFC};
            st_q <= smi_pkg::ST_GAP;
          end
        end
        smi_pkg::ST_ASU: begin
          if (cnt_q == 16'h0000) begin
            cnt_q <= {10'h000, acfg_strobe};
            st_q <= smi_pkg::ST_AST;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        smi_pkg::ST_AST: begin
          // wait stretches the strobe until the cap is hit
          if (cnt_q == 16'h0000) begin
            if (wait_act && wcnt_q != wait_max) begin
              wcnt_q <= wcnt_q + 8'h01;
            end else begin
              cnt_q <= {13'h0000, hold_eff};
              st_q <= smi_pkg::ST_AHO;
            end
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        smi_pkg::ST_AHO: begin
          if (cnt_q == 16'h0000) begin
            st_q <= smi_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: st_q <= smi_pkg::ST_INIT;
      endcase
    end
  end

  // timeout event: strobe ends with wait still active at the cap
  logic tmo_evt;
  assign tmo_evt = (st_q == smi_pkg::ST_AST) && cnt_q == 16'h0000 && wait_act
    && wcnt_q == wait_max;

  // -----------------------------------------------------------------
  // interrupt status and mask
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_raw <= 1'b0;
    end else if (tmo_evt) begin
      irq_raw <= 1'b1;
    end else if (irq_clear) begin
      irq_raw <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_mask <= 1'b0;
    end else if (irq_mask_set) begin
      irq_mask <= 1'b1;
    end else if (irq_mask_clr) begin
      irq_mask <= 1'b0;
    end
  end
  assign irq_masked = irq_raw & irq_mask;
  assign irq = irq_masked;

  // -----------------------------------------------------------------
  // read data capture
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rsp_rdata <= 32'h0000_0000;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (!req_w_q && ((st_q == smi_pkg::ST_RW && cnt_q == 16'h0000) ||
          (st_q == smi_pkg::ST_AST && cnt_q == 16'h0000 && !(wait_act &&
          wcnt_q != wait_max)))) begin
        rsp_rdata <= sdcfg_narrow ? {16'h0000, dq_in[15:0]} : dq_in;
        rsp_valid <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // pin drive, registered
  // -----------------------------------------------------------------
  logic is_async;
  assign is_async = st_q == smi_pkg::ST_ASU || st_q == smi_pkg::ST_AST
    || st_q == smi_pkg::ST_AHO;
  logic [2:0] cmd;
  always_comb begin
    case (st_q)
      smi_pkg::ST_ACT: cmd = (cnt_q == {12'h000, smi_pkg::SD_GAP}) ? smi_pkg::CMD_ACT
        : smi_pkg::CMD_NOP;
      smi_pkg::ST_RW: cmd = (cnt_q == {12'h000, smi_pkg::SD_GAP}) ?
        (req_w_q ? smi_pkg::CMD_WR : smi_pkg::CMD_RD) : smi_pkg::CMD_NOP;
      smi_pkg::ST_IPRE, smi_pkg::ST_PRE: cmd = smi_pkg::CMD_PRE;
      smi_pkg::ST_REF, smi_pkg::ST_SELF: cmd = smi_pkg::CMD_REF;
      smi_pkg::ST_IREF: cmd = (cnt_q == 16'h0000 && nref_q != 4'h0) ? smi_pkg::CMD_REF
        : smi_pkg::CMD_NOP;
      smi_pkg::ST_IMRS: cmd = smi_pkg::CMD_MRS;
      default: cmd = smi_pkg::CMD_NOP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {ras_n, cas_n, we_n} <= smi_pkg::CMD_NOP;
      sdram_chip_sel_n <= 1'b1;
      async_chip_sel_n <= 1'b1;
      byte_strobe_lines_n <= 4'hF;
      mem_addr_bus <= 13'h0000;
      bank_addr_lines <= 2'h0;
      oe_n <= 1'b1;
      read_write_level <= 1'b1;
      dq_out <= smi_pkg::PARK_VAL;
      dq_oe_n <= 1'b0;
      self_refresh_ack <= 1'b0;
    end else begin
      // dedicated selects: zero for sdram, two for async
      sdram_chip_sel_n <= is_async || cmd == smi_pkg::CMD_NOP;
      self_refresh_ack <= st_q == smi_pkg::ST_SELF;
      dq_oe_n <= 1'b0;
      if (is_async) begin
        {ras_n, cas_n, we_n} <= {2'b11, !(req_w_q && st_q == smi_pkg::ST_AST)};
        mem_addr_bus <= addr_q[12:0];
        bank_addr_lines <= (acfg_width == 2'h2) ? 2'h0 : {addr_q[13], addr_q[14]};
        read_write_level <= !req_w_q;
        oe_n <= !(!req_w_q && st_q == smi_pkg::ST_AST);
        dq_oe_n <= !req_w_q; // reads release the bus
        dq_out <= wdat_q;
        if (acfg_we_strobe) begin
          async_chip_sel_n <= 1'b0;
          byte_strobe_lines_n <= (st_q == smi_pkg::ST_AST) ? ~be_q : 4'hF;
        end else begin
          async_chip_sel_n <= st_q != smi_pkg::ST_AST;
          byte_strobe_lines_n <= ~be_q;
        end
      end else begin
        {ras_n, cas_n, we_n} <= cmd;
        async_chip_sel_n <= 1'b1;
        oe_n <= 1'b1;
        read_write_level <= 1'b1;
        // lanes masked outside the access, so idle never looks like a strobe
        byte_strobe_lines_n <= (st_q == smi_pkg::ST_RW) ? ~be_q : 4'hF;
        // mode value on mode set, row on activate, column otherwise; bank on its own lines
        // a10 high: auto precharge on read/write, all banks on precharge
        mem_addr_bus <= (st_q == smi_pkg::ST_IMRS) ? smi_pkg::MODE_VAL :
          (st_q == smi_pkg::ST_ACT) ? row_q :
          {4'h2, col_q};
        bank_addr_lines <= bank_q;
        if (st_q == smi_pkg::ST_RW && req_w_q) begin
          dq_out <= wdat_q;
        end else if (st_q == smi_pkg::ST_IDLE) begin
          dq_out <= smi_pkg::PARK_VAL;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/smi_mem_model.sv ====
// behavioural sdram and async memory seen at the memory pins
`timescale 1ns/1ps
`default_nettype none
module smi_mem_model (
  // clock
  input wire logic clk,
  // pins from the controller
  input wire logic [12:0] mem_addr_bus,
  input wire logic [1:0] bank_addr_lines,
  input wire logic sdram_chip_sel_n,
  input wire logic async_chip_sel_n,
  input wire logic [3:0] byte_strobe_lines_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic read_write_level,
  input wire logic [31:0] dq_out,
  // pins back to the controller
  output logic [31:0] dq_in,
  output logic ext_wait_in,
  // wait shaping from the bench
  input wire logic [7:0] wait_len,
  input wire logic wait_act
);
  logic [31:0] sd_mem [0:1023]; // {bank, column}, rows folded
  logic [31:0] as_mem [0:255]; // async store by low address
  logic [9:0] rd_idx_q;
  logic [2:0] rd_cnt_q = 3'h0; // cycles the read data still stands
  logic [7:0] acc_cnt_q = 8'h00; // cycles into the async access
  logic [31:0] last_q = 32'h0000_0000; // last value driven
  logic [2:0] cmd;
  logic as_busy;
  logic drive;
  logic [31:0] val;
  assign cmd = sdram_chip_sel_n ? smi_pkg::CMD_NOP : {ras_n, cas_n, we_n};
  assign as_busy = !async_chip_sel_n || (byte_strobe_lines_n != 4'hf);
  assign drive = (rd_cnt_q != 3'h0) || (!async_chip_sel_n && !oe_n);
  assign val = (rd_cnt_q != 3'h0) ? sd_mem[rd_idx_q] : as_mem[mem_addr_bus[7:0]];
  // a released bus shows the inverse, so a stale sample cannot pass
  assign dq_in = drive ? val : ~last_q;
  // no power-up limit here, so no software recovery is needed
  assign ext_wait_in = (as_busy && acc_cnt_q < wait_len) ? wait_act : !wait_act;
  // sdram: store on write, data stands a few cycles around cas latency
  always @(posedge clk) begin
    if (drive) last_q <= val;
    if (cmd == smi_pkg::CMD_WR) sd_mem[{bank_addr_lines, mem_addr_bus[7:0]}] <= dq_out;
    if (cmd == smi_pkg::CMD_RD) begin
      rd_idx_q <= {bank_addr_lines, mem_addr_bus[7:0]};
      rd_cnt_q <= 3'h6;
    end else if (rd_cnt_q != 3'h0) begin
      rd_cnt_q <= rd_cnt_q - 3'h1;
    end
  end
  // async: write lands in the strobe, which both modes mark by select and lanes
  always @(posedge clk) begin
    acc_cnt_q <= as_busy ? acc_cnt_q + 8'h01 : 8'h00;
    if (!async_chip_sel_n && byte_strobe_lines_n != 4'hf && !read_write_level) begin
      as_mem[mem_addr_bus[7:0]] <= dq_out;
    end
  end
endmodule
`default_nettype wire

// ==== verif/smi_top_properties.sv ====
// concurrent checks on the memory interface ports
`timescale 1ns/1ps
`default_nettype none
module smi_top_properties (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // watched ports
  input wire logic req_ready,
  input wire logic sdram_chip_sel_n,
  input wire logic async_chip_sel_n,
  input wire logic [3:0] byte_strobe_lines_n,
  input wire logic oe_n,
  input wire logic read_write_level,
  input wire logic dq_oe_n,
  input wire logic acfg_we_strobe,
  input wire logic irq_mask_set,
  input wire logic irq_mask_clr,
  input wire logic irq_raw,
  input wire logic irq_masked,
  input wire logic irq_mask,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence init_quiet;
    !req_ready [*8];
  endsequence
  sequence lanes_on;
    byte_strobe_lines_n != 4'hf;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sel_exclusive_a: assert property (!(!sdram_chip_sel_n && !async_chip_sel_n))
    else $error("both chip selects active");
  idle_park_a: assert property (req_ready && $past(req_ready) |-> !dq_oe_n)
    else $error("data bus released while idle");
  reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
    !nrst |=> sdram_chip_sel_n && async_chip_sel_n && !dq_oe_n && !irq_raw)
    else $error("pins not quiet in reset");
  init_busy_a: assert property ($rose(nrst) |-> init_quiet)
    else $error("ready without init after reset");
  sel_hold_a: assert property (!acfg_we_strobe && $rose(async_chip_sel_n) |-> lanes_on)
    else $error("no hold cycle after select strobe");
  sel_setup_a: assert property (!acfg_we_strobe && $fell(async_chip_sel_n) |->
    lanes_on and $past(byte_strobe_lines_n) != 4'hf)
    else $error("byte enables missing in setup");
  we_setup_a: assert property (acfg_we_strobe && $fell(async_chip_sel_n) |->
    byte_strobe_lines_n == 4'hf)
    else $error("write strobe in setup period");
  rw_read_a: assert property (!async_chip_sel_n && !oe_n |-> read_write_level)
    else $error("read level low during read");
  mask_set_a: assert property (irq_mask_set && !irq_mask_clr |=> irq_mask)
    else $error("mask set ignored");
  mask_clear_a: assert property (irq_mask_clr && !irq_mask_set |=> !irq_mask)
    else $error("mask clear ignored");
  irq_gate_a: assert property (irq == (irq_raw && irq_mask) && irq_masked == irq)
    else $error("interrupt not raw and mask");
endmodule
bind smi_top smi_top_properties u_props (.clk(clk), .nrst(nrst), .req_ready(req_ready),
  .sdram_chip_sel_n(sdram_chip_sel_n), .async_chip_sel_n(async_chip_sel_n),
  .byte_strobe_lines_n(byte_strobe_lines_n), .oe_n(oe_n),
  .read_write_level(read_write_level), .dq_oe_n(dq_oe_n), .acfg_we_strobe(acfg_we_strobe),
  .irq_mask_set(irq_mask_set), .irq_mask_clr(irq_mask_clr), .irq_raw(irq_raw),
  .irq_masked(irq_masked), .irq_mask(irq_mask), .irq(irq));
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the memory interface
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, nrst = 0, req_valid = 0, req_async = 0, req_write = 0;
  logic [23:0] req_addr = 0;
  logic [3:0] req_be = 4'hf;
  logic [31:0] req_wdata = 0, rsp_rdata, dq_out, dq_in, got;
  logic [2:0] sdcfg_wr_bytes = 0;
  logic sdcfg_narrow = 0, self_refresh_req = 0, acfg_we_strobe = 0, wait_pol = 1;
  logic [12:0] refr_interval = 13'h0400, mem_addr_bus, ad_seen, col;
  logic [1:0] acfg_width = 2'h2, bank_addr_lines, ba_seen, act_ba;
  logic [3:0] acfg_setup = 4'h1, byte_strobe_lines_n;
  logic [5:0] acfg_strobe = 6'h02;
  logic [2:0] acfg_hold = 3'h0;
  logic [7:0] wait_max = 8'h04, wait_len = 0;
  logic irq_clear = 0, irq_mask_set = 0, irq_mask_clr = 0, wait_act = 1, rw_seen;
  logic req_ready, rsp_valid, self_refresh_ack, irq_raw, irq_masked, irq_mask, irq;
  logic sdram_chip_sel_n, async_chip_sel_n, ras_n, cas_n, we_n, oe_n;
  logic read_write_level, dq_oe_n, ext_wait_in;
  int error_cnt = 0, compares = 0, cyc = 0, ref_cnt = 0, cs_n, ln_n, r0, i, m;
  always #25 clk = ~clk;
  smi_top DUT (.*);
  smi_mem_model u_mem (.clk(clk), .mem_addr_bus(mem_addr_bus),
    .bank_addr_lines(bank_addr_lines), .sdram_chip_sel_n(sdram_chip_sel_n),
    .async_chip_sel_n(async_chip_sel_n), .byte_strobe_lines_n(byte_strobe_lines_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
    .read_write_level(read_write_level), .dq_out(dq_out), .dq_in(dq_in),
    .ext_wait_in(ext_wait_in), .wait_len(wait_len), .wait_act(wait_act));
  // refresh commands seen, and a ceiling on the run
  always @(posedge clk) begin
    if (!sdram_chip_sel_n && {ras_n, cas_n, we_n} == smi_pkg::CMD_REF) ref_cnt++;
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // all stimulus moves shortly after the rising edge
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic wait_rdy(input logic lvl, input int lim);
    for (i = 0; i < lim && req_ready !== lvl; i++) @(negedge clk);
    tick();
  endtask
  // one request, then a window that counts strobes and captures pins
  task automatic acc(input logic a, input logic w, input logic [23:0] ad,
                     input logic [31:0] wd);
    tick();
    {req_valid, req_async, req_write, req_addr, req_wdata} = {1'b1, a, w, ad, wd};
    @(negedge clk);
    wait_rdy(1'b1, 300);
    req_valid = 0;
    cs_n = 0;
    ln_n = 0;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk);
      if (a && cs_n + ln_n == 0 && (!async_chip_sel_n || byte_strobe_lines_n != 4'hf))
        {ad_seen, ba_seen, rw_seen} = {mem_addr_bus, bank_addr_lines, read_write_level};
      if (!async_chip_sel_n) cs_n++;
      if (a && byte_strobe_lines_n != 4'hf) ln_n++;
      if (!sdram_chip_sel_n && {ras_n, cas_n, we_n} == smi_pkg::CMD_ACT) act_ba = bank_addr_lines;
      if (!sdram_chip_sel_n && {ras_n, cas_n, we_n} == smi_pkg::CMD_RD) col = mem_addr_bus;
      if (rsp_valid === 1'b1) got = rsp_rdata;
    end
    tick();
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #2 nrst = 1;
    tick();
    check("ready_in_init", req_ready, 0);
    wait_rdy(1'b1, 6000);
    check("ready_after_init", req_ready, 1);
    check("idle_parked", dq_oe_n, 0);
    $display("test reset done");
    acc(0, 1, 24'h000010, 32'h1234_5678);
    check("act_bank0", act_ba, 2'h0);
    acc(0, 1, 24'h000110, 32'h9abc_def0);
    check("act_bank1", act_ba, 2'h1);
    acc(0, 0, 24'h000010, 0);
    check("sd_rd0", got, 32'h1234_5678);
    check("sd_col", col[7:0], 8'h10);
    acc(0, 0, 24'h000110, 0);
    check("sd_rd1", got, 32'h9abc_def0);
    $display("test sdram done");
    for (m = 0; m < 2; m++) begin
      acfg_we_strobe = m[0];
      acc(1, 1, 24'h000025 + m, 32'h5a5a_0000 + m);
      check("cs_cycles", cs_n, m ? 6 : 3);
      check("lane_cycles", ln_n, m ? 3 : 6);
      check("word_addr", ad_seen, 13'h0025 + m);
      check("rw_write", rw_seen, 0);
      acc(1, 0, 24'h000025 + m, 0);
      check("async_rd", got, 32'h5a5a_0000 + m);
      check("rw_read", rw_seen, 1);
    end
    acfg_width = 2'h1;
    acc(1, 0, 24'h002005, 0);
    check("half_bank", ba_seen, 2'h2);
    check("half_addr", ad_seen, 13'h0005);
    acfg_width = 2'h2;
    $display("test async done");
    {wait_pol, wait_len, irq_mask_set} = {1'b0, 8'h3c, 1'b1};
    tick();
    irq_mask_set = 0;
    acc(1, 1, 24'h000030, 0);
    check("wrong_pol", irq_raw, 0);
    wait_pol = 1;
    acc(1, 1, 24'h000030, 0);
    check("timeout_raw", irq_raw, 1);
    check("timeout_done", req_ready, 1);
    check("timeout_irq", irq, 1);
    irq_mask_clr = 1;
    tick();
    irq_mask_clr = 0;
    tick();
    check("masked_off", irq, 0);
    check("raw_kept", irq_raw, 1);
    irq_clear = 1;
    tick();
    {irq_clear, wait_len} = 0;
    tick();
    check("raw_cleared", irq_raw, 0);
    $display("test wait done");
    {refr_interval, r0} = {13'h0040, ref_cnt};
    repeat (1300) tick();
    check("refreshes", ref_cnt - r0 >= 2, 1);
    refr_interval = 13'h0400;
    self_refresh_req = 1;
    for (i = 0; i < 300 && self_refresh_ack !== 1'b1; i++) tick();
    check("sr_ack", self_refresh_ack, 1);
    check("sr_busy", req_ready, 0);
    self_refresh_req = 0;
    @(negedge clk);
    wait_rdy(1'b1, 300);
    acc(0, 0, 24'h000010, 0);
    check("sr_data_kept", got, 32'h1234_5678);
    $display("test refresh done");
    sdcfg_wr_bytes = 3'h1;
    tick();
    sdcfg_wr_bytes = 0;
    @(negedge clk);
    wait_rdy(1'b0, 50);
    check("cfg_init_busy", req_ready, 0);
    wait_rdy(1'b1, 6000);
    check("cfg_init_done", req_ready, 1);
    $display("test config done");
    close_out();
  end
endmodule
`default_nettype wire
